// ===== design/pss_steer_top.sv
// top of the pwm steering block with power-state and reset behaviour
//
// Functional notes
// - sync select 0: new steering applies right after the write
// - sync select 1: steering waits for the next pwm period start
// - sleep stops the period timer and freezes all unit state
// - during sleep every pwm pin keeps its driven level
// - after wake the unit resumes from frozen state, no reinit
// - primary idle keeps the unit running unchanged
// - clock failure with monitor on: internal mode, set fail flag
// - any reset makes pins inputs and registers take reset values
// - bit 4 is sync select, bits 3-0 steer pins d..a
// - steering only in mode bits 11 and config 00; low bits polarity (here bit 1 alone sets it for all pins, bit 0 unused)
// - shutdown affects only pins enabled by steering
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pss_steer_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic clk_fail_pin,
    input wire logic shutdown_pin,
    input wire logic [3:0] port_out,
    output logic [7:0] rdata,
    output logic [3:0] pwm_output_pins,
    output logic [3:0] pin_oe,
    output logic irq
);
    // ********************************************************
    // registers
    // ********************************************************
    logic [7:0] control_q;
    logic [4:0] steer_q;
    logic [7:0] tctrl_q;
    logic [7:0] tcount_q;
    logic [7:0] tlimit_q;
    logic [7:0] duty_q;
    logic [2:0] power_q;
    logic [2:0] status_q;
    logic [2:0] irq_en_q;
    logic [3:0] dir_q;
    logic [3:0] active_steer;
    logic [3:0] pending_steer;
    logic fail_s;
    logic shut_s;
    logic fail_prev_q;
    logic shut_prev_q;
    logic rc_mode_q;
    pss_pkg::pss_power_e pstate_q;
    pss_pkg::pss_bus_s bus;
    pss_pkg::pss_steer_s steer_wr;
    logic freeze;
    logic period_start;
    logic steer_mode;
    logic pwm_raw;
    logic pwm_pol;
    logic [2:0] events;
    logic [3:0] pins_d;

    // bus fields and the steering write view
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign steer_wr = '{sync_sel: wdata[pss_pkg::STEER_SYNC_BIT],
                        enables: wdata[3:0]};

    // ********************************************************
    // input synchronisers
    // ********************************************************
    // clock-fail and shutdown pins cross into the mclk domain
    pss_sync2 u_fail (
        .mclk(mclk),
        .rst(rst),
        .din(clk_fail_pin),
        .dout(fail_s)
    );

    pss_sync2 u_shut (
        .mclk(mclk),
        .rst(rst),
        .din(shutdown_pin),
        .dout(shut_s)
    );

    // ********************************************************
    // power state
    // ********************************************************
    // sleep freezes; idle and internal mode keep running
    always_ff @(posedge mclk) begin
        if (rst) begin
            pstate_q <= pss_pkg::PSS_RUN;
        end else if (power_q[pss_pkg::PWR_SLEEP_BIT]) begin
            pstate_q <= pss_pkg::PSS_SLEEP;
        end else if (rc_mode_q) begin
            pstate_q <= pss_pkg::PSS_RCRUN;
        end else if (fail_s && power_q[pss_pkg::PWR_MON_BIT]) begin
            pstate_q <= pss_pkg::PSS_RCRUN;
        end else if (power_q[pss_pkg::PWR_IDLE_BIT]) begin
            pstate_q <= pss_pkg::PSS_IDLE;
        end else begin
            pstate_q <= pss_pkg::PSS_RUN;
        end
    end

    assign freeze = (pstate_q == pss_pkg::PSS_SLEEP);

    // internal oscillator mode stays until reset, also across sleep
    always_ff @(posedge mclk) begin
        if (rst) begin
            rc_mode_q <= 1'b0;
        end else if (fail_s && power_q[pss_pkg::PWR_MON_BIT]) begin
            rc_mode_q <= 1'b1;
        end
    end

    // ********************************************************
    // period timer
    // ********************************************************
    // period boundary: running count has reached the limit
    assign period_start = tctrl_q[pss_pkg::TIMER_ON_BIT] && !freeze
                          && (tcount_q == tlimit_q);

    // count to limit then restart; host writes take priority
    always_ff @(posedge mclk) begin
        if (rst) begin
            tcount_q <= pss_pkg::TCOUNT_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_TCOUNT) begin
            tcount_q <= bus.wdata;
        end else if (period_start) begin
            tcount_q <= 8'h00;
        end else if (tctrl_q[pss_pkg::TIMER_ON_BIT] && !freeze) begin
            tcount_q <= tcount_q + 8'h01;
        end
    end

    // ********************************************************
    // steering
    // ********************************************************
    // immediate or period-synchronised steering update
    pss_steer_latch u_latch (
        .mclk(mclk),
        .rst(rst),
        .freeze(freeze),
        .wr(bus.wr && bus.addr == pss_pkg::OFF_STEER),
        .wdata(steer_wr),
        .period_start(period_start),
        .active_q(active_steer),
        .pending_q(pending_steer)
    );

    // single-output mode decode and output polarity
    assign steer_mode = (control_q[3:2] == 2'b11)
                        && (control_q[7:6] == 2'b00);
    assign pwm_raw = (tcount_q < duty_q);
    assign pwm_pol = control_q[1] ? ~pwm_raw : pwm_raw;

    // ********************************************************
    // pin drive
    // ********************************************************
    // per pin: steered waveform, shutdown level or port data
    generate
        for (genvar i = 0; i < 4; i++) begin : g_pin
            always_comb begin
                if (steer_mode && active_steer[i]) begin
                    pins_d[i] = shut_s ? 1'b0 : pwm_pol;
                end else begin
                    pins_d[i] = port_out[i];
                end
            end
        end
    endgenerate

    // pins hold their level while frozen
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_output_pins <= 4'h0;
        end else if (!freeze) begin
            pwm_output_pins <= pins_d;
        end else begin
            pwm_output_pins <= pwm_output_pins;
        end
    end

    // output enables follow the direction register, held in sleep
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_oe <= 4'h0;
        end else if (!freeze) begin
            pin_oe <= ~dir_q;
        end else begin
            pin_oe <= pin_oe;
        end
    end

    // ********************************************************
    // register writes
    // ********************************************************
    // mode, polarity and output configuration
    always_ff @(posedge mclk) begin
        if (rst) begin
            control_q <= pss_pkg::CONTROL_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_CONTROL) begin
            control_q <= bus.wdata;
        end
    end

    // steering register copy for read-back
    always_ff @(posedge mclk) begin
        if (rst) begin
            steer_q <= pss_pkg::STEER_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_STEER) begin
            steer_q <= bus.wdata[4:0];
        end
    end

    // period timer control
    always_ff @(posedge mclk) begin
        if (rst) begin
            tctrl_q <= pss_pkg::TCTRL_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_TCTRL) begin
            tctrl_q <= bus.wdata;
        end
    end

    // period timer limit
    always_ff @(posedge mclk) begin
        if (rst) begin
            tlimit_q <= pss_pkg::TLIMIT_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_TLIMIT) begin
            tlimit_q <= bus.wdata;
        end
    end

    // duty threshold of the waveform
    always_ff @(posedge mclk) begin
        if (rst) begin
            duty_q <= pss_pkg::DUTY_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_DUTY) begin
            duty_q <= bus.wdata;
        end
    end

    // interrupt enables
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_en_q <= pss_pkg::IRQ_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_IRQ_EN) begin
            irq_en_q <= bus.wdata[2:0];
        end
    end

    // pin direction, all inputs after reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_q <= pss_pkg::DIR_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_DIR) begin
            dir_q <= bus.wdata[3:0];
        end
    end

    // power control; a wake write clears sleep
    always_ff @(posedge mclk) begin
        if (rst) begin
            power_q <= pss_pkg::POWER_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_POWER) begin
            power_q <= bus.wdata[2:0];
        end
    end

    // ********************************************************
    // events and interrupt
    // ********************************************************
    // previous synced fail level, held in sleep so no edge is lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            fail_prev_q <= 1'b0;
        end else if (!freeze) begin
            fail_prev_q <= fail_s;
        end
    end

    // previous synced shutdown level, held in sleep
    always_ff @(posedge mclk) begin
        if (rst) begin
            shut_prev_q <= 1'b0;
        end else if (!freeze) begin
            shut_prev_q <= shut_s;
        end
    end

    // one-cycle event pulses for the status bits
    assign events[pss_pkg::ST_PERIOD_BIT] = period_start;
    assign events[pss_pkg::ST_OSCFAIL_BIT] = fail_s && !fail_prev_q
        && power_q[pss_pkg::PWR_MON_BIT] && !freeze;
    assign events[pss_pkg::ST_SHUT_BIT] = shut_s && !shut_prev_q
        && !freeze;

    // sticky status, set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_q <= pss_pkg::IRQ_RST;
        end else if (bus.wr && bus.addr == pss_pkg::OFF_IRQ_CLR) begin
            status_q <= (status_q & ~bus.wdata[2:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    // level interrupt from enabled sticky bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_q | events) & irq_en_q);
        end
    end

    // ********************************************************
    // register reads
    // ********************************************************
    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                pss_pkg::OFF_CONTROL: rdata <= control_q;
                pss_pkg::OFF_STEER: rdata <= {3'h0, steer_q};
                pss_pkg::OFF_TCTRL: rdata <= tctrl_q;
                pss_pkg::OFF_TCOUNT: rdata <= tcount_q;
                pss_pkg::OFF_TLIMIT: rdata <= tlimit_q;
                pss_pkg::OFF_DUTY: rdata <= duty_q;
                pss_pkg::OFF_POWER: rdata <= {3'h0, pstate_q, power_q};
                pss_pkg::OFF_STATUS: rdata <= {5'h00, status_q};
                pss_pkg::OFF_IRQ_EN: rdata <= {5'h00, irq_en_q};
                pss_pkg::OFF_DIR: rdata <= {pending_steer, dir_q};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : pss_steer_top

// ===== design/pss_pkg.sv
// package: register map, field layout and types of the pwm steering block
package pss_pkg;
    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_STEER = 4'h1;
    localparam logic [3:0] OFF_TCTRL = 4'h2;
    localparam logic [3:0] OFF_TCOUNT = 4'h3;
    localparam logic [3:0] OFF_TLIMIT = 4'h4;
    localparam logic [3:0] OFF_DUTY = 4'h5;
    localparam logic [3:0] OFF_POWER = 4'h6;
    localparam logic [3:0] OFF_STATUS = 4'h7;
    localparam logic [3:0] OFF_IRQ_EN = 4'h8;
    localparam logic [3:0] OFF_IRQ_CLR = 4'h9;
    localparam logic [3:0] OFF_DIR = 4'hA;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int STEER_SYNC_BIT = 4;
    localparam int TIMER_ON_BIT = 2;
    localparam int PWR_SLEEP_BIT = 0;
    localparam int PWR_IDLE_BIT = 1;
    localparam int PWR_MON_BIT = 2;
    localparam int ST_PERIOD_BIT = 0;
    localparam int ST_OSCFAIL_BIT = 1;
    localparam int ST_SHUT_BIT = 2;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [4:0] STEER_RST = 5'h01;
    localparam logic [7:0] TCTRL_RST = 8'h00;
    localparam logic [7:0] TCOUNT_RST = 8'h00;
    localparam logic [7:0] TLIMIT_RST = 8'hFF;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [2:0] POWER_RST = 3'h0;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [3:0] DIR_RST = 4'hF;

    // ********************************************************
    // types
    // ********************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pss_bus_s;

    typedef struct packed {
        logic sync_sel;
        logic [3:0] enables;
    } pss_steer_s;

    typedef enum logic [1:0] {
        PSS_RUN,
        PSS_IDLE,
        PSS_SLEEP,
        PSS_RCRUN
    } pss_power_e;
endpackage : pss_pkg

// ===== design/pss_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pss_sync2 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : pss_sync2

// ===== design/pss_steer_latch.sv
// steer assignment holder: immediate or period-synchronised update
`timescale 1ns/1ps
module pss_steer_latch (
    input wire logic mclk,
    input wire logic rst,
    input wire logic freeze,
    input wire logic wr,
    input wire pss_pkg::pss_steer_s wdata,
    input wire logic period_start,
    output logic [3:0] active_q,
    output logic [3:0] pending_q
);
    logic pend_valid_q;

    // pending copy, last write wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            pending_q <= pss_pkg::STEER_RST[3:0];
            pend_valid_q <= 1'b0;
        end else if (!freeze) begin
            if (wr && wdata.sync_sel) begin
                pending_q <= wdata.enables;
                pend_valid_q <= 1'b1;
            end else if (wr || period_start) begin
                pend_valid_q <= 1'b0;
            end
        end
    end

    // applied assignment
    always_ff @(posedge mclk) begin
        if (rst) begin
            active_q <= pss_pkg::STEER_RST[3:0];
        end else if (!freeze) begin
            if (wr && !wdata.sync_sel) begin
                active_q <= wdata.enables;
            end else if (period_start && pend_valid_q) begin
                active_q <= pending_q;
            end
        end
    end
endmodule : pss_steer_latch

// ===== verification/pss_steer_assertions.sv
// port assertions for the pwm steering block
`timescale 1ns/1ps
module pss_steer_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] port_out,
    input wire logic [7:0] rdata,
    input wire logic [3:0] pwm_output_pins,
    input wire logic [3:0] pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ********************************
    // port relations
    // ********************************
    a_reset_quiet: assert property (
        $fell(rst) |-> pin_oe == 4'h0 && pwm_output_pins == 4'h0 && !irq)
        else $error("outputs not quiet after reset");
    a_dir_drives_oe: assert property (
        wr && addr == pss_pkg::OFF_DIR ##1 !(wr && addr == pss_pkg::OFF_DIR)
        |=> pin_oe == ~$past(wdata[3:0], 2))
        else $error("output enables do not follow direction");
    a_dir_readback: assert property (
        wr && addr == pss_pkg::OFF_DIR ##1 rd && addr == pss_pkg::OFF_DIR
        |=> rdata[3:0] == $past(wdata[3:0], 2))
        else $error("direction reads back wrong");
    a_limit_readback: assert property (
        wr && addr == pss_pkg::OFF_TLIMIT ##1 rd && addr == pss_pkg::OFF_TLIMIT
        |=> rdata == $past(wdata, 2))
        else $error("period limit reads back wrong");
    a_unsteered_port: assert property (
        wr && addr == pss_pkg::OFF_STEER && wdata[4:0] == 5'h00
        |=> ##1 pwm_output_pins == $past(port_out))
        else $error("unsteered pins do not show port data");
    a_steer_all_same: assert property (
        wr && addr == pss_pkg::OFF_STEER && wdata[4:0] == 5'h0F
        |=> ##1 pwm_output_pins == 4'h0 || pwm_output_pins == 4'hF)
        else $error("steered pins disagree");
    a_irq_masked: assert property (
        wr && addr == pss_pkg::OFF_IRQ_EN && wdata[2:0] == 3'h0
        ##1 !(wr && addr == pss_pkg::OFF_IRQ_EN) |=> !irq)
        else $error("interrupt high while masked");
    a_unmapped_zero: assert property (
        rd && addr > pss_pkg::OFF_DIR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : pss_steer_checker

bind pss_steer_top pss_steer_checker i_checker (
    .mclk, .rst, .addr, .wdata, .wr, .rd, .port_out, .rdata,
    .pwm_output_pins, .pin_oe, .irq
);

// ===== verification/pss_bridge_model.sv
// model of the external bridge driver whose fault output drives the shutdown pin
`timescale 1ns/1ps
module pss_bridge_model (
    input wire logic mclk,
    input wire logic trip,
    output logic fault
);
    logic fault_q = 1'b0;
    // overcurrent fault reported one cycle after the trip
    always_ff @(posedge mclk) begin
        fault_q <= trip;
    end
    assign fault = fault_q;
endmodule : pss_bridge_model

// ===== verification/pss_steer_top_test.sv
// self-checking testbench for the pwm steering block
`timescale 1ns/1ps
module pss_steer_top_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clk_fail_pin = 1'b0;
    logic shutdown_pin;
    logic trip = 1'b0;
    logic [3:0] port_out = 4'h0;
    logic [7:0] rdata;
    logic [3:0] pins;
    logic [3:0] pin_oe;
    logic irq;
    logic [7:0] rv;
    logic [7:0] cnt;
    logic [3:0] held;
    int fails = 0;
    int checked = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    pss_steer_top i_dut (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .clk_fail_pin(clk_fail_pin),
        .shutdown_pin(shutdown_pin), .port_out(port_out), .rdata(rdata),
        .pwm_output_pins(pins), .pin_oe(pin_oe), .irq(irq));
    pss_bridge_model i_bridge (.mclk(mclk), .trip(trip),
        .fault(shutdown_pin));

    // ********************************
    // bus and compare tasks
    // ********************************
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_n
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        wait_n(1);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        rd <= 1'b1;
        addr <= a;
        wait_n(1);
        rd <= 1'b0;
        rv = rdata;
        @(posedge mclk);
    endtask : rd_reg
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
                         input logic [7:0] m);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        rd_reg(a);
        chk("readback", d & m, rv & m);
    endtask : wr_rd
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // watchdog against a hung run
    initial begin
        #50000;
        fails++;
        print_verdict();
    end

    // ********************************
    // test sequence
    // ********************************
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(pss_pkg::OFF_STEER);
        chk("steer reset", 8'h01, rv & 8'h1F);
        rd_reg(pss_pkg::OFF_TLIMIT);
        chk("limit reset", 8'hFF, rv);
        chk("oe reset", 8'h00, {4'h0, pin_oe});
        wr_rd(pss_pkg::OFF_DIR, 8'h00, 8'h0F);
        chk("oe driven", 8'h0F, {4'h0, pin_oe});
        wr_rd(pss_pkg::OFF_TLIMIT, 8'h09, 8'hFF);
        wr_reg(pss_pkg::OFF_DUTY, 8'h05);
        wr_reg(pss_pkg::OFF_CONTROL, 8'h0C);
        wr_reg(pss_pkg::OFF_TCTRL, 8'h04);
        port_out <= 4'hA;
        wr_reg(pss_pkg::OFF_STEER, 8'h00);
        chk("port pins", 8'h0A, {4'h0, pins});
        wr_reg(pss_pkg::OFF_STEER, 8'h0F);
        chk("same pins", 8'h01, {7'h0, pins == 4'h0 || pins == 4'hF});
        // freeze the waveform high with the timer stopped at zero
        wr_reg(pss_pkg::OFF_TCTRL, 8'h00);
        wr_reg(pss_pkg::OFF_TCOUNT, 8'h00);
        port_out <= 4'h0;
        wait_n(2);
        chk("pins high", 8'h0F, {4'h0, pins});
        wr_reg(pss_pkg::OFF_CONTROL, 8'h0E);
        wait_n(1);
        chk("pins inverted", 8'h00, {4'h0, pins});
        wr_reg(pss_pkg::OFF_CONTROL, 8'h0C);
        wr_reg(pss_pkg::OFF_STEER, 8'h12);
        wr_reg(pss_pkg::OFF_STEER, 8'h14);
        rd_reg(pss_pkg::OFF_DIR);
        chk("pending", 8'h40, rv & 8'hF0);
        chk("pins held", 8'h0F, {4'h0, pins});
        wr_reg(pss_pkg::OFF_TCTRL, 8'h04);
        wait_n(15);
        chk("pins applied", 8'h00, {4'h0, pins & 4'hB});
        // sleep freezes count and pins
        wr_reg(pss_pkg::OFF_POWER, 8'h01);
        held = pins;
        rd_reg(pss_pkg::OFF_TCOUNT);
        cnt = rv;
        wait_n(20);
        chk("sleep pins", {4'h0, held}, {4'h0, pins});
        rd_reg(pss_pkg::OFF_TCOUNT);
        chk("sleep count", cnt, rv);
        rd_reg(pss_pkg::OFF_POWER);
        chk("sleep state", 8'h10, rv & 8'h18);
        wr_reg(pss_pkg::OFF_POWER, 8'h00);
        wait_n(1);
        rd_reg(pss_pkg::OFF_TCOUNT);
        chk("wake count", (cnt + 8'h01) % 8'h0A, rv);
        // idle keeps the timer running at full rate
        wr_reg(pss_pkg::OFF_POWER, 8'h02);
        rd_reg(pss_pkg::OFF_TCOUNT);
        cnt = rv;
        rd_reg(pss_pkg::OFF_POWER);
        chk("idle state", 8'h08, rv & 8'h18);
        rd_reg(pss_pkg::OFF_TCOUNT);
        chk("idle count", (cnt + 8'h04) % 8'h0A, rv);
        // clock failure with the monitor on
        wr_reg(pss_pkg::OFF_POWER, 8'h04);
        clk_fail_pin <= 1'b1;
        wait_n(6);
        rd_reg(pss_pkg::OFF_STATUS);
        chk("fail flag", 8'h02, rv & 8'h02);
        rd_reg(pss_pkg::OFF_POWER);
        chk("rc state", 8'h18, rv & 8'h18);
        wr_reg(pss_pkg::OFF_IRQ_EN, 8'h02);
        chk("irq on", 8'h01, {7'h0, irq});
        wr_reg(pss_pkg::OFF_IRQ_EN, 8'h00);
        wait_n(1);
        chk("irq masked", 8'h00, {7'h0, irq});
        clk_fail_pin <= 1'b0;
        wait_n(4);
        wr_reg(pss_pkg::OFF_IRQ_CLR, 8'h02);
        wr_reg(pss_pkg::OFF_IRQ_EN, 8'h02);
        chk("irq cleared", 8'h00, {7'h0, irq});
        rd_reg(pss_pkg::OFF_STATUS);
        chk("flag cleared", 8'h00, rv & 8'h02);
        // shutdown touches only the steered pin c
        port_out <= 4'hF;
        trip <= 1'b1;
        wait_n(8);
        chk("shutdown pins", 8'h0B, {4'h0, pins});
        rd_reg(pss_pkg::OFF_STATUS);
        chk("shutdown flag", 8'h04, rv & 8'h04);
        trip <= 1'b0;
        rd_reg(4'hF);
        chk("unmapped", 8'h00, rv);
        // second reset in mid-run
        rst <= 1'b1;
        wait_n(4);
        rst <= 1'b0;
        rd_reg(pss_pkg::OFF_STEER);
        chk("steer again", 8'h01, rv & 8'h1F);
        chk("oe again", 8'h00, {4'h0, pin_oe});
        print_verdict();
    end
endmodule : pss_steer_top_test
